// >>> src/port_ext_interrupt_unit.sv
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps

module port_ext_interrupt_unit (
    // clock and reset
    input  wire  logic                                hclk,
    input  wire  logic                                hresetn,
    // ahb-lite slave
    input  wire  logic                                hsel,
    input  wire  logic [31:0]                         haddr,
    input  wire  logic [1:0]                          htrans,
    input  wire  logic                                hwrite,
    input  wire  logic [2:0]                          hsize,
    input  wire  logic [31:0]                         hwdata,
    input  wire  logic                                hready,
    output logic       [31:0]                         hrdata,
    output logic                                      hreadyout,
    output logic                                      hresp,
    // cpu sideband
    input  wire  logic                                rmw_access,
    input  wire  logic                                hold_enter,
    input  wire  logic                                irq_accept,
    // pins
    input  wire  logic [port_ext_pkg::PIN_COUNT-1:0]  pin_in,
    output logic       [port_ext_pkg::PIN_COUNT-1:0]  pin_out,
    output logic       [port_ext_pkg::PIN_COUNT-1:0]  pin_oe_n,
    output logic       [port_ext_pkg::PIN_COUNT-1:0]  pullup_en,
    // interrupt and power
    output logic       [port_ext_pkg::PIN_COUNT-1:0]  irq_req,
    output logic       [7:0]                          irq_vector,
    output logic                                      hold_release,
    output port_ext_pkg::power_state_type             power_state,
    output logic                                      cr_osc_run,
    // timer 0 strobes
    output logic                                      t0_count,
    output logic                                      t0_capture_lo,
    output logic                                      t0_capture_hi
);
    import port_ext_pkg::*;

    logic [7:0]           pin_ctrl_q;
    logic [7:0]           ab_ctrl_q;
    logic [7:0]           cd_ctrl_q;
    logic [7:0]           isl_q;
    logic [3:0]           sync1_q;
    logic [3:0]           sync2_q;
    logic [3:0]           prev_q;
    logic [3:0]           rise;
    logic [3:0]           fall;
    logic [3:0]           cond;
    logic [3:0]           flag_set;
    logic [1:0]           entry_lvl_q;
    logic                 wr_pend_q;
    logic [31:0]          addr_q;
    logic                 addr_ok;
    logic                 wr_pin;
    logic                 wr_ab;
    logic                 wr_cd;
    logic                 wr_isl;
    logic [7:0]           wbyte;
    logic [7:0]           rd_byte;
    logic [3:0]           pending;
    logic [3:0]           release_ok;
    logic                 in_hold;
    power_state_type      state_q;

    ////////////////////////////////////////////////////////////////////////
    // bus slave

    assign addr_ok   = hsel && htrans == HTRANS_NONSEQ && hready;
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign wbyte     = hwdata[7:0];
    assign wr_pin    = wr_pend_q && addr_q == PIN_GROUP_CTRL_ADDR;
    assign wr_ab     = wr_pend_q && addr_q == EXT_IRQ_AB_CTRL_ADDR;
    assign wr_cd     = wr_pend_q && addr_q == EXT_IRQ_CD_CTRL_ADDR;
    assign wr_isl    = wr_pend_q && addr_q == INPUT_SIGNAL_SELECT_ADDR;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            addr_q    <= 32'h0;
        end
        else
        begin
            wr_pend_q <= addr_ok && hwrite;
            if (addr_ok)
                addr_q <= haddr;
        end
    end

    always_comb
    begin
        rd_byte = 8'h00;
        if (haddr == PIN_GROUP_CTRL_ADDR)
        begin
            rd_byte[7:DIR_LSB] = pin_ctrl_q[7:DIR_LSB];
            if (rmw_access)
                rd_byte[3:DATA_LSB] = pin_ctrl_q[3:DATA_LSB];
            else
                rd_byte[3:DATA_LSB] = sync2_q;
        end
        else if (haddr == EXT_IRQ_AB_CTRL_ADDR)
            rd_byte = ab_ctrl_q;
        else if (haddr == EXT_IRQ_CD_CTRL_ADDR)
            rd_byte = cd_ctrl_q;
        else if (haddr == INPUT_SIGNAL_SELECT_ADDR)
            rd_byte = isl_q;
    end

    // read data captured in the address phase, zero wait states
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0;
        else if (addr_ok && !hwrite)
            hrdata <= {24'h0, rd_byte};
    end

    ////////////////////////////////////////////////////////////////////////
    // port control and pins

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pin_ctrl_q <= PIN_GROUP_CTRL_RST;
        else if (wr_pin)
            pin_ctrl_q <= wbyte;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            isl_q <= INPUT_SIGNAL_SELECT_RST;
        else if (wr_isl)
            isl_q <= wbyte;
    end

    always_comb
    begin
        pin_out   = pin_ctrl_q[3:DATA_LSB];
        pin_oe_n  = ~pin_ctrl_q[7:DIR_LSB];
        pullup_en = pin_ctrl_q[3:DATA_LSB];
        // open drain pin a: only ever pulls low
        pin_out[0]  = 1'b0;
        pin_oe_n[0] = ~(pin_ctrl_q[DIR_LSB] & ~pin_ctrl_q[DATA_LSB]);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            prev_q  <= 4'h0;
        end
        else
        begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign rise = sync2_q & ~prev_q;
    assign fall = ~sync2_q & prev_q;

    ////////////////////////////////////////////////////////////////////////
    // detectors

    always_comb
    begin
        // a and b: polarity and level/edge
        cond[0] = ab_ctrl_q[DET_A_LEVEL_SEL]
                ? (ab_ctrl_q[DET_A_POLARITY] ? sync2_q[0] : ~sync2_q[0])
                : (ab_ctrl_q[DET_A_POLARITY] ? rise[0] : fall[0]);
        cond[1] = ab_ctrl_q[DET_B_LEVEL_SEL]
                ? (ab_ctrl_q[DET_B_POLARITY] ? sync2_q[1] : ~sync2_q[1])
                : (ab_ctrl_q[DET_B_POLARITY] ? rise[1] : fall[1]);
        // c and d: edges only
        cond[2] = (cd_ctrl_q[DET_C_RISE_EN] & rise[2])
                | (cd_ctrl_q[DET_C_FALL_EN] & fall[2]);
        cond[3] = (cd_ctrl_q[DET_D_RISE_EN] & rise[3])
                | (cd_ctrl_q[DET_D_FALL_EN] & fall[3]);
        flag_set = cond;
        if (in_hold)
        begin
            // edges on a/b cannot set flags while held
            flag_set[0] = cond[0] & ab_ctrl_q[DET_A_LEVEL_SEL];
            flag_set[1] = cond[1] & ab_ctrl_q[DET_B_LEVEL_SEL];
            // edge toward the level seen at hold entry is ignored
            flag_set[2] = cond[2] & (entry_lvl_q[0] ? fall[2] : rise[2]);
            flag_set[3] = cond[3] & (entry_lvl_q[1] ? fall[3] : rise[3]);
        end
    end

    // set wins over a clearing write
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ab_ctrl_q <= EXT_IRQ_AB_CTRL_RST;
        else
        begin
            if (wr_ab)
                ab_ctrl_q <= wbyte;
            if (flag_set[0])
                ab_ctrl_q[DET_A_FLAG] <= 1'b1;
            if (flag_set[1])
                ab_ctrl_q[DET_B_FLAG] <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cd_ctrl_q <= EXT_IRQ_CD_CTRL_RST;
        else
        begin
            if (wr_cd)
                cd_ctrl_q <= wbyte;
            if (flag_set[2])
                cd_ctrl_q[DET_C_FLAG] <= 1'b1;
            if (flag_set[3])
                cd_ctrl_q[DET_D_FLAG] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // requests, hold release and power state

    assign pending[0] = ab_ctrl_q[DET_A_FLAG] & ab_ctrl_q[DET_A_ENABLE];
    assign pending[1] = ab_ctrl_q[DET_B_FLAG] & ab_ctrl_q[DET_B_ENABLE];
    assign pending[2] = cd_ctrl_q[DET_C_FLAG] & cd_ctrl_q[DET_C_ENABLE];
    assign pending[3] = cd_ctrl_q[DET_D_FLAG] & cd_ctrl_q[DET_D_ENABLE];
    assign irq_req    = pending;

    assign release_ok = {2'b11, ab_ctrl_q[DET_B_LEVEL_SEL],
                         ab_ctrl_q[DET_A_LEVEL_SEL]};
    assign hold_release = |(pending & release_ok);
    assign in_hold      = state_q == pwr_hold;
    assign power_state  = state_q;
    assign cr_osc_run   = state_q != pwr_hold;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_vector <= 8'h00;
        else if (pending[0])
            irq_vector <= VECTOR_A;
        else if (pending[1])
            irq_vector <= VECTOR_B;
        else if (pending[2])
            irq_vector <= VECTOR_C;
        else if (pending[3])
            irq_vector <= VECTOR_D;
        else
            irq_vector <= 8'h00;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_q <= pwr_run;
        else
        begin
            unique case (state_q)
                pwr_run:
                    if (hold_enter)
                        state_q <= pwr_hold;
                pwr_hold:
                    if (hold_release)
                        state_q <= pwr_halt;
                pwr_halt:
                    if (irq_accept)
                        state_q <= pwr_run;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            entry_lvl_q <= 2'b00;
        else if (state_q == pwr_run && hold_enter)
            entry_lvl_q <= sync2_q[3:2];
    end

    ////////////////////////////////////////////////////////////////////////
    // timer 0 strobes; level conditions repeat every cycle

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            t0_count      <= 1'b0;
            t0_capture_lo <= 1'b0;
            t0_capture_hi <= 1'b0;
        end
        else
        begin
            t0_count <= isl_q[COUNT_SOURCE_SEL]
                      ? flag_set[3] : flag_set[2];
            t0_capture_lo <= isl_q[LOW_CAPTURE_SOURCE_SEL]
                           ? flag_set[0] : flag_set[2];
            t0_capture_hi <= isl_q[HIGH_CAPTURE_SOURCE_SEL]
                           ? flag_set[1] : flag_set[3];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    flag_sticky_a: assert property (
        ab_ctrl_q[DET_A_FLAG] && !wr_ab |=> ab_ctrl_q[DET_A_FLAG])
        else $error("detector a flag dropped without write");

    flag_set_wins_a: assert property (
        flag_set[2] |=> cd_ctrl_q[DET_C_FLAG])
        else $error("detector c flag not set after condition");

    release_pend_a: assert property (
        $rose(pending[3]) |-> hold_release && irq_req[3])
        else $error("detector d pending without release");

    vector_a_a: assert property (
        pending[0] |=> irq_vector == VECTOR_A)
        else $error("detector a vector wrong");

    open_drain_a: assert property (
        pin_ctrl_q[DIR_LSB] && pin_ctrl_q[DATA_LSB] |-> pin_oe_n[0])
        else $error("pin a driven while data is one");

    drive_dir_a: assert property (
        pin_ctrl_q[7] |-> !pin_oe_n[3] && pin_out[3] == pin_ctrl_q[3])
        else $error("pin d not driven with its data");

    rmw_read_a: assert property (
        addr_ok && !hwrite && rmw_access
        && haddr == PIN_GROUP_CTRL_ADDR
        |=> hrdata[7:0] == $past(pin_ctrl_q))
        else $error("rmw read did not return latched data");

    pin_read_a: assert property (
        addr_ok && !hwrite && !rmw_access
        && haddr == PIN_GROUP_CTRL_ADDR
        |=> hrdata[3:0] == $past(sync2_q))
        else $error("pin read did not return pin levels");

    count_sel_a: assert property (
        isl_q[COUNT_SOURCE_SEL] && flag_set[3] |=> t0_count)
        else $error("count pulse missing for pin d");

    level_repeat_a: assert property (
        isl_q[LOW_CAPTURE_SOURCE_SEL] && ab_ctrl_q[DET_A_LEVEL_SEL]
        && !ab_ctrl_q[DET_A_POLARITY] && !in_hold
        && !sync2_q[0] [*3] |=> t0_capture_lo)
        else $error("level capture did not repeat");

    hold_to_halt_a: assert property (
        in_hold && hold_release |=> state_q == pwr_halt ##0 cr_osc_run)
        else $error("hold release did not enter halt");

    edge_hold_a: assert property (
        in_hold && !ab_ctrl_q[DET_B_LEVEL_SEL] |-> !flag_set[1])
        else $error("edge on pin b set flag during hold");

endmodule

// >>> src/port_ext_pkg.sv
package port_ext_pkg;

    // register indices; the bus byte address is four times the index
    localparam logic [15:0] PIN_GROUP_CTRL_IDX      = 16'hfe5c;
    localparam logic [15:0] EXT_IRQ_AB_CTRL_IDX     = 16'hfe5d;
    localparam logic [15:0] EXT_IRQ_CD_CTRL_IDX     = 16'hfe5e;
    localparam logic [15:0] INPUT_SIGNAL_SELECT_IDX = 16'hfe5f;

    localparam logic [31:0] PIN_GROUP_CTRL_ADDR =
        {14'h0, PIN_GROUP_CTRL_IDX, 2'b00};
    localparam logic [31:0] EXT_IRQ_AB_CTRL_ADDR =
        {14'h0, EXT_IRQ_AB_CTRL_IDX, 2'b00};
    localparam logic [31:0] EXT_IRQ_CD_CTRL_ADDR =
        {14'h0, EXT_IRQ_CD_CTRL_IDX, 2'b00};
    localparam logic [31:0] INPUT_SIGNAL_SELECT_ADDR =
        {14'h0, INPUT_SIGNAL_SELECT_IDX, 2'b00};

    localparam logic [7:0] PIN_GROUP_CTRL_RST      = 8'h00;
    localparam logic [7:0] EXT_IRQ_AB_CTRL_RST     = 8'h00;
    localparam logic [7:0] EXT_IRQ_CD_CTRL_RST     = 8'h00;
    localparam logic [7:0] INPUT_SIGNAL_SELECT_RST = 8'h00;

    localparam int PIN_COUNT = 4;
    localparam int DATA_LSB  = 0;
    localparam int DIR_LSB   = 4;

    // ext_irq_ab_ctrl fields
    localparam int DET_A_ENABLE    = 0;
    localparam int DET_A_FLAG      = 1;
    localparam int DET_A_LEVEL_SEL = 2;
    localparam int DET_A_POLARITY  = 3;
    localparam int DET_B_ENABLE    = 4;
    localparam int DET_B_FLAG      = 5;
    localparam int DET_B_LEVEL_SEL = 6;
    localparam int DET_B_POLARITY  = 7;

    // ext_irq_cd_ctrl fields
    localparam int DET_C_ENABLE  = 0;
    localparam int DET_C_FLAG    = 1;
    localparam int DET_C_FALL_EN = 2;
    localparam int DET_C_RISE_EN = 3;
    localparam int DET_D_ENABLE  = 4;
    localparam int DET_D_FLAG    = 5;
    localparam int DET_D_FALL_EN = 6;
    localparam int DET_D_RISE_EN = 7;

    // input_signal_select fields
    localparam int COUNT_SOURCE_SEL        = 0;
    localparam int LOW_CAPTURE_SOURCE_SEL  = 6;
    localparam int HIGH_CAPTURE_SOURCE_SEL = 7;

    localparam logic [7:0] VECTOR_A = 8'h03;
    localparam logic [7:0] VECTOR_B = 8'h0b;
    localparam logic [7:0] VECTOR_C = 8'h13;
    localparam logic [7:0] VECTOR_D = 8'h1b;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    typedef enum logic [1:0] {
        pwr_run,
        pwr_hold,
        pwr_halt
    } power_state_type;

endpackage

// >>> tb/pin_source_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// external sources on the four port pins, with the wire resolved
module pin_source_model (
    // clock
    input  wire logic       hclk,
    // source control from the bench
    input  wire logic [3:0] drive_en,
    input  wire logic [3:0] drive_val,
    // port side of the block
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe_n,
    input  wire logic [3:0] pullup_en,
    // resolved pin levels
    output logic      [3:0] pin_level
);
    // undriven wire with no pull-up: a pattern that never settles
    logic [3:0] float_q = 4'h5;

    always @(posedge hclk)
    begin
        float_q <= ~float_q;
    end

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (!pin_oe_n[i])
                pin_level[i] = pin_out[i];
            else if (drive_en[i])
                pin_level[i] = drive_val[i];
            else if (pullup_en[i])
                pin_level[i] = 1'b1;
            else
                pin_level[i] = float_q[i];
        end
    end
endmodule

// >>> tb/port_ext_interrupt_unit_test.sv
`timescale 1ns/1ps

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end

module port_ext_interrupt_unit_test;
    import port_ext_pkg::*;

    logic                  hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0]           haddr, hwdata, hrdata, rd, seed;
    logic [1:0]            htrans;
    logic [2:0]            hsize;
    logic                  rmw_access, hold_enter, irq_accept;
    logic [3:0]            pin_in, pin_out, pin_oe_n, pullup_en, irq_req;
    logic [3:0]            drv_en, drv_val, drv, en;
    logic [7:0]            irq_vector, r, cfg;
    logic                  hold_release, cr_osc_run, pol, lvl;
    logic                  t0_count, t0_capture_lo, t0_capture_hi;
    power_state_type       power_state;
    int                    mismatches, compares, n_cnt, n_lo, n_hi;
    int                    d, m, e;

    port_ext_interrupt_unit dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rmw_access(rmw_access), .hold_enter(hold_enter),
        .irq_accept(irq_accept), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pullup_en(pullup_en), .irq_req(irq_req),
        .irq_vector(irq_vector), .hold_release(hold_release),
        .power_state(power_state), .cr_osc_run(cr_osc_run),
        .t0_count(t0_count), .t0_capture_lo(t0_capture_lo),
        .t0_capture_hi(t0_capture_hi)
    );

    pin_source_model pins (
        .hclk(hclk), .drive_en(drv_en), .drive_val(drv_val),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
        .pin_level(pin_in)
    );

    ////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // level seen on each pin: block drive, source drive, else pull-up
    function automatic logic [3:0] exp_level(input logic [7:0] c,
        input logic [3:0] se, input logic [3:0] sv);
        logic [3:0] bd;
        bd = c[7:4] & {3'b111, ~c[0]};
        return (bd & c[3:0]) | (~bd & se & sv) | (~bd & ~se);
    endfunction

    task automatic cyc(input int k);
        repeat (k) @(posedge hclk);
    endtask

    // no cycle limit: only the watchdog ends a wait
    task automatic wait_ready;
        do
            @(posedge hclk);
        while (hreadyout !== 1'b1);
    endtask

    task automatic bus(input logic wr, input logic [31:0] a,
        input logic [7:0] wd, input logic rmw);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        rmw_access <= rmw;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        rmw_access <= 1'b0;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata;
        `CHK(hresp, HRESP_OKAY)
    endtask

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // clock, strobe counters, watchdog
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    always @(negedge hclk)
    begin
        if (t0_count === 1'b1) n_cnt++;
        if (t0_capture_lo === 1'b1) n_lo++;
        if (t0_capture_hi === 1'b1) n_hi++;
    end

    initial
    begin
        #600000;
        mismatches++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        hresetn = 1'b0;
        {hsel, hwrite, rmw_access, hold_enter, irq_accept} = 5'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        drv_en = 4'hf;
        drv_val = 4'h0;
        seed = 32'h01edfae4;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b0, PIN_GROUP_CTRL_ADDR + 32'(4 * i), 8'h00, 1'b0);
            `CHK(rd, 32'h0)
        end
        `CHK(pin_oe_n, 4'hf)
        `CHK(pullup_en, 4'h0)
        bus(1'b1, 32'h0003_f980, 8'hff, 1'b0);
        bus(1'b0, 32'h0003_f980, 8'h00, 1'b0);
        `CHK(rd, 32'h0)
        $display("reset and map test done");

        for (int i = 0; i < 12; i++)
        begin
            seed = lfsr(seed);
            r = (i == 0) ? 8'h1f : (i == 1) ? 8'hf0 : seed[7:0];
            drv = r[7:4] & {3'b111, ~r[0]};
            en = ~drv & (seed[11:8] | ~r[3:0]);
            drv_en <= en;
            drv_val <= seed[15:12];
            bus(1'b1, PIN_GROUP_CTRL_ADDR, r, 1'b0);
            cyc(4);
            `CHK(pin_oe_n, ~drv)
            `CHK(pin_oe_n[0], ~(r[4] & ~r[0]))
            `CHK(pin_out & drv, r[3:0] & drv)
            `CHK(pullup_en, r[3:0])
            bus(1'b0, PIN_GROUP_CTRL_ADDR, 8'h00, 1'b0);
            `CHK(rd[7:0], {r[7:4], exp_level(r, en, seed[15:12])})
            `CHK(rd[3:0] & drv, r[3:0] & drv)
            bus(1'b0, PIN_GROUP_CTRL_ADDR, 8'h00, 1'b1);
            `CHK(rd[7:0], r)
        end
        $display("port test done");

        bus(1'b1, PIN_GROUP_CTRL_ADDR, 8'h00, 1'b0);
        drv_en <= 4'hf;
        drv_val <= 4'h0;
        bus(1'b1, INPUT_SIGNAL_SELECT_ADDR, 8'hc0, 1'b0);
        for (d = 0; d < 2; d++)
        for (m = 0; m < 4; m++)
        begin
            pol = m[1];
            lvl = m[0];
            cfg = 8'({pol, lvl, 2'b01}) << (4 * d);
            drv_val[d] <= ~pol;
            cyc(4);
            bus(1'b1, EXT_IRQ_AB_CTRL_ADDR, cfg, 1'b0);
            cyc(4);
            n_lo = 0;
            n_hi = 0;
            drv_val[d] <= pol;
            cyc(10);
            drv_val[d] <= ~pol;
            cyc(5);
            bus(1'b0, EXT_IRQ_AB_CTRL_ADDR, 8'h00, 1'b0);
            `CHK(rd[7:0], cfg | (8'h02 << (4 * d)))
            `CHK(irq_req, 4'(1 << d))
            `CHK(irq_vector, d ? VECTOR_B : VECTOR_A)
            `CHK(hold_release, lvl)
            `CHK(d ? n_hi : n_lo, lvl ? 10 : 1)
            bus(1'b1, EXT_IRQ_AB_CTRL_ADDR, cfg, 1'b0);
            bus(1'b0, EXT_IRQ_AB_CTRL_ADDR, 8'h00, 1'b0);
            `CHK(rd[7:0], cfg)
            `CHK(irq_req, 4'h0)
        end
        $display("detector a b test done");

        for (d = 0; d < 2; d++)
        for (m = 0; m < 4; m++)
        begin
            cfg = 8'({m[1:0], 2'b01}) << (4 * d);
            e = m[0] + m[1];
            bus(1'b1, INPUT_SIGNAL_SELECT_ADDR, 8'(d), 1'b0);
            bus(1'b1, EXT_IRQ_CD_CTRL_ADDR, cfg, 1'b0);
            cyc(3);
            n_cnt = 0;
            n_lo = 0;
            n_hi = 0;
            drv_val[d + 2] <= 1'b1;
            cyc(6);
            drv_val[d + 2] <= 1'b0;
            cyc(6);
            `CHK(n_cnt, e)
            `CHK(d ? n_hi : n_lo, e)
            bus(1'b0, EXT_IRQ_CD_CTRL_ADDR, 8'h00, 1'b0);
            `CHK(rd[7:0], cfg | (m ? 8'h02 << (4 * d) : 8'h00))
            `CHK(irq_vector, m ? (d ? VECTOR_D : VECTOR_C) : 8'h00)
            bus(1'b1, EXT_IRQ_CD_CTRL_ADDR, cfg, 1'b0);
        end
        $display("detector c d test done");

        bus(1'b1, EXT_IRQ_AB_CTRL_ADDR, 8'h90, 1'b0);
        bus(1'b1, EXT_IRQ_CD_CTRL_ADDR, 8'h05, 1'b0);
        hold_enter <= 1'b1;
        @(posedge hclk);
        hold_enter <= 1'b0;
        cyc(2);
        `CHK(power_state, pwr_hold)
        `CHK(cr_osc_run, 1'b0)
        // pin b rises in edge mode, pin c falls toward its entry level
        drv_val[2:1] <= 2'b11;
        cyc(6);
        drv_val[2:1] <= 2'b00;
        cyc(6);
        `CHK(power_state, pwr_hold)
        `CHK(irq_req, 4'h0)
        // both edges so that the wake-up is not lost
        bus(1'b1, EXT_IRQ_CD_CTRL_ADDR, 8'h0d, 1'b0);
        drv_val[2] <= 1'b1;
        cyc(6);
        `CHK(irq_req, 4'h4)
        `CHK(power_state, pwr_halt)
        `CHK(cr_osc_run, 1'b1)
        irq_accept <= 1'b1;
        @(posedge hclk);
        irq_accept <= 1'b0;
        cyc(2);
        `CHK(power_state, pwr_run)
        // rise only, entered high: the rise is ignored
        bus(1'b1, EXT_IRQ_CD_CTRL_ADDR, 8'h09, 1'b0);
        hold_enter <= 1'b1;
        @(posedge hclk);
        hold_enter <= 1'b0;
        drv_val[2] <= 1'b0;
        cyc(6);
        drv_val[2] <= 1'b1;
        cyc(6);
        `CHK(power_state, pwr_hold)
        `CHK(irq_req, 4'h0)
        $display("hold test done");
        tally_and_finish();
    end
endmodule
